// file: shared/jisp_pkg.sv
package jisp_pkg;
  // ==========================================================
  // scan port sizes
  localparam int IR_LEN = 10; // instruction register length
  localparam int ID_LEN = 32; // identification / user code length
  localparam int DR_MAX = 32; // widest data register
  // ==========================================================
  // instruction codes (any code not listed acts as bypass)
  localparam logic [9:0] INS_IDCODE = 10'h006;
  localparam logic [9:0] INS_USERCODE = 10'h007;
  localparam logic [9:0] INS_ENTER = 10'h010;
  localparam logic [9:0] INS_EXIT = 10'h011;
  localparam logic [9:0] INS_ERASE = 10'h012;
  localparam logic [9:0] INS_PROGRAM = 10'h013;
  localparam logic [9:0] INS_READ = 10'h014;
  localparam logic [9:0] INS_BYPASS = 10'h3ff;
  localparam logic [9:0] IR_CAPTURE = 10'h001; // fixed pattern loaded at capture
  localparam logic [9:0] IR_RESET = INS_IDCODE; // instruction after test reset
  // ==========================================================
  // stage timing
  localparam int CLK_MHZ = 200; // system clock rate
  localparam int ENTER_TIME_US = 1000; // enter stage, 1 ms
  localparam int EXIT_TIME_US = 1000; // exit stage, 1 ms
  localparam int ERASE_TIME_MS = 100; // single bulk erase pulse
  localparam int ENTER_CYCLES = ENTER_TIME_US * CLK_MHZ;
  localparam int EXIT_CYCLES = EXIT_TIME_US * CLK_MHZ;
  localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000 * CLK_MHZ;
  localparam int PROG_CYCLES = 256; // program pulse length
  localparam int READ_CYCLES = 16; // read pulse length
  localparam int FIFO_DEPTH = 16; // verify read-back buffer
  // ==========================================================
  // reset values
  localparam logic RESET_DONE_FLAG = 1'b0; // blank part: outputs stay off
  // ==========================================================
  // test access port states
  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001, TAP_IDLE = 16'h0002, TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008, TAP_SHIFT_DR = 16'h0010, TAP_EXIT1_DR = 16'h0020,
    TAP_PAUSE_DR = 16'h0040, TAP_EXIT2_DR = 16'h0080, TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SHIFT_IR = 16'h0800,
    TAP_EXIT1_IR = 16'h1000, TAP_PAUSE_IR = 16'h2000, TAP_EXIT2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } jisp_tap_t;
  // programming stage sequencer
  typedef enum logic [6:0] {
    SEQ_USER = 7'h01, SEQ_ENTER = 7'h02, SEQ_ISP = 7'h04, SEQ_EXIT = 7'h08,
    SEQ_ERASE = 7'h10, SEQ_PROG = 7'h20, SEQ_READ = 7'h40
  } jisp_seq_t;
endpackage

// file: rtl/jisp_fifo.sv
`timescale 1ns/1ps
module jisp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  // ==========================================================
  // storage and pointers (depth must be a power of two)
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] slots [DEPTH]; // word storage
  logic [PW:0] wrPtr; // extra bit tells full from empty
  logic [PW:0] rdPtr;
  logic [PW:0] next_wrPtr;
  logic [PW:0] next_rdPtr;
  logic full;
  logic empty;

  assign full = (wrPtr[PW] != rdPtr[PW]) && (wrPtr[PW-1:0] == rdPtr[PW-1:0]);
  assign empty = (wrPtr == rdPtr);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = slots[rdPtr[PW-1:0]];

  // ==========================================================
  // pointer update
  always_comb begin
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    if (inValid && !full) begin
      next_wrPtr = wrPtr + 1'b1;
    end
    if (outReady && !empty) begin
      next_rdPtr = rdPtr + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
  end

  // storage carries no reset; contents are only read once written
  always_ff @(posedge clk) begin
    if (inValid && !full) begin
      slots[wrPtr[PW-1:0]] <= inData;
    end
  end
endmodule // jisp_fifo

// file: rtl/jisp_sequencer.sv
`timescale 1ns/1ps
module jisp_sequencer #(
  parameter int ADDR_W = 8, // cell array address width
  parameter int DATA_W = 16, // cell array word width
  parameter logic [31:0] ID_CODE = 32'h0a5a_c0d1, // arbitrary value
  parameter logic [31:0] USER_CODE = 32'h0000_0000, // user signature
  parameter int ENTER_CYCLES = jisp_pkg::ENTER_CYCLES,
  parameter int EXIT_CYCLES = jisp_pkg::EXIT_CYCLES,
  parameter int ERASE_CYCLES = jisp_pkg::ERASE_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdoEnable,
  output logic userOutEnable,
  output logic pullUpEnable,
  output logic programmingCompleteFlag
);
  // ==========================================================
  // helpers
  // next scan controller state for a given mode select
  function automatic jisp_pkg::jisp_tap_t tapNext(input jisp_pkg::jisp_tap_t s, input logic m);
    unique case (s)
      jisp_pkg::TAP_RESET: tapNext = m ? jisp_pkg::TAP_RESET : jisp_pkg::TAP_IDLE;
      jisp_pkg::TAP_IDLE: tapNext = m ? jisp_pkg::TAP_SEL_DR : jisp_pkg::TAP_IDLE;
      jisp_pkg::TAP_SEL_DR: tapNext = m ? jisp_pkg::TAP_SEL_IR : jisp_pkg::TAP_CAP_DR;
      jisp_pkg::TAP_CAP_DR: tapNext = m ? jisp_pkg::TAP_EXIT1_DR : jisp_pkg::TAP_SHIFT_DR;
      jisp_pkg::TAP_SHIFT_DR: tapNext = m ? jisp_pkg::TAP_EXIT1_DR : jisp_pkg::TAP_SHIFT_DR;
      jisp_pkg::TAP_EXIT1_DR: tapNext = m ? jisp_pkg::TAP_UPD_DR : jisp_pkg::TAP_PAUSE_DR;
      jisp_pkg::TAP_PAUSE_DR: tapNext = m ? jisp_pkg::TAP_EXIT2_DR : jisp_pkg::TAP_PAUSE_DR;
      jisp_pkg::TAP_EXIT2_DR: tapNext = m ? jisp_pkg::TAP_UPD_DR : jisp_pkg::TAP_SHIFT_DR;
      jisp_pkg::TAP_UPD_DR: tapNext = m ? jisp_pkg::TAP_SEL_DR : jisp_pkg::TAP_IDLE;
      jisp_pkg::TAP_SEL_IR: tapNext = m ? jisp_pkg::TAP_RESET : jisp_pkg::TAP_CAP_IR;
      jisp_pkg::TAP_CAP_IR: tapNext = m ? jisp_pkg::TAP_EXIT1_IR : jisp_pkg::TAP_SHIFT_IR;
      jisp_pkg::TAP_SHIFT_IR: tapNext = m ? jisp_pkg::TAP_EXIT1_IR : jisp_pkg::TAP_SHIFT_IR;
      jisp_pkg::TAP_EXIT1_IR: tapNext = m ? jisp_pkg::TAP_UPD_IR : jisp_pkg::TAP_PAUSE_IR;
      jisp_pkg::TAP_PAUSE_IR: tapNext = m ? jisp_pkg::TAP_EXIT2_IR : jisp_pkg::TAP_PAUSE_IR;
      jisp_pkg::TAP_EXIT2_IR: tapNext = m ? jisp_pkg::TAP_UPD_IR : jisp_pkg::TAP_SHIFT_IR;
      jisp_pkg::TAP_UPD_IR: tapNext = m ? jisp_pkg::TAP_SEL_DR : jisp_pkg::TAP_IDLE;
      default: tapNext = jisp_pkg::TAP_RESET; // illegal one-hot code
    endcase
  endfunction

  // data register length selected by the current instruction
  function automatic int unsigned drLen(input logic [9:0] ins);
    unique case (ins)
      jisp_pkg::INS_IDCODE, jisp_pkg::INS_USERCODE: drLen = jisp_pkg::ID_LEN;
      jisp_pkg::INS_PROGRAM: drLen = ADDR_W + DATA_W;
      jisp_pkg::INS_READ: drLen = (DATA_W > ADDR_W) ? DATA_W : ADDR_W;
      default: drLen = 1; // bypass
    endcase
  endfunction

  // ==========================================================
  // pin synchronisers: two flops before any logic reads a pin
  logic tckS1, tckS2, tckPrev; // tckPrev only for edge finding
  logic tmsS1, tmsS2;
  logic tdiS1, tdiS2;
  logic tckRise;
  logic tckFall;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {tckS1, tckS2, tckPrev} <= 3'h0;
      {tmsS1, tmsS2} <= 2'h3; // idle high keeps controller in reset
      {tdiS1, tdiS2} <= 2'h3;
    end else begin
      {tckS1, tckS2, tckPrev} <= {tck, tckS1, tckS2};
      {tmsS1, tmsS2} <= {tms, tmsS1};
      {tdiS1, tdiS2} <= {tdi, tdiS1};
    end
  end

  assign tckRise = tckS2 && !tckPrev;
  assign tckFall = !tckS2 && tckPrev;

  // ==========================================================
  // state
  jisp_pkg::jisp_tap_t tap, next_tap; // scan controller
  jisp_pkg::jisp_seq_t seq, next_seq; // programming stage
  logic [9:0] ir, next_ir; // active instruction
  logic [9:0] irShift, next_irShift; // instruction shift stage
  logic [31:0] dr, next_dr; // shared data shift stage
  logic [31:0] timer, next_timer; // pulse / transition countdown
  logic [ADDR_W-1:0] addr, next_addr; // cell address latched at update
  logic [DATA_W-1:0] wdata, next_wdata; // word to program
  logic readPending, next_readPending; // verify read waiting for buffer room
  logic next_done; // completion flag, nonvolatile in silicon
  logic next_tdo, next_tdoEnable, next_userOutEnable, next_pullUpEnable;
  logic memWrite, memErase; // cell array strobes
  logic fifoPush, fifoPop, fifoInReady, fifoOutValid;
  logic [DATA_W-1:0] fifoOutData;
  logic [DATA_W-1:0] cells [2**ADDR_W]; // nonvolatile array model

  // ==========================================================
  // next-state logic
  always_comb begin
    next_tap = tap;
    next_seq = seq;
    next_ir = ir;
    next_irShift = irShift;
    next_dr = dr;
    next_timer = timer;
    next_addr = addr;
    next_wdata = wdata;
    next_readPending = readPending;
    next_done = programmingCompleteFlag;
    next_tdo = tdo;
    next_tdoEnable = tdoEnable;
    memWrite = 1'b0;
    memErase = 1'b0;
    fifoPush = 1'b0;
    fifoPop = 1'b0;
    // all scan activity keys off the sampled test clock edge
    if (tckRise) begin
      next_tap = tapNext(tap, tmsS2);
      if (tap == jisp_pkg::TAP_RESET) begin
        next_ir = jisp_pkg::IR_RESET;
      end
      if (tap == jisp_pkg::TAP_CAP_IR) begin
        next_irShift = jisp_pkg::IR_CAPTURE;
      end
      // instruction enters lsb first through the 10-bit stage
      if (tap == jisp_pkg::TAP_SHIFT_IR) begin
        next_irShift = {tdiS2, irShift[9:1]};
      end
      if (tap == jisp_pkg::TAP_UPD_IR) begin
        next_ir = irShift;
        // stage starts are ignored unless the sequencer is in the right stage
        if (irShift == jisp_pkg::INS_ENTER && seq == jisp_pkg::SEQ_USER) begin
          next_seq = jisp_pkg::SEQ_ENTER;
          next_timer = 32'(ENTER_CYCLES - 1);
        end else if (irShift == jisp_pkg::INS_EXIT && seq == jisp_pkg::SEQ_ISP) begin
          next_seq = jisp_pkg::SEQ_EXIT;
          next_timer = 32'(EXIT_CYCLES - 1);
        end else if (irShift == jisp_pkg::INS_ERASE && seq == jisp_pkg::SEQ_ISP) begin
          next_seq = jisp_pkg::SEQ_ERASE;
          next_timer = 32'(ERASE_CYCLES - 1);
        end
      end
      if (tap == jisp_pkg::TAP_CAP_DR) begin
        unique case (ir)
          jisp_pkg::INS_IDCODE: next_dr = {ID_CODE[31:1], 1'b1};
          jisp_pkg::INS_USERCODE: next_dr = USER_CODE;
          jisp_pkg::INS_READ: begin
            // oldest verify result, zero when none is waiting
            next_dr = fifoOutValid ? 32'(fifoOutData) : 32'h0;
            fifoPop = fifoOutValid;
          end
          default: next_dr = 32'h0;
        endcase
      end
      // new bit lands at the top of the selected length
      if (tap == jisp_pkg::TAP_SHIFT_DR) begin
        next_dr = dr >> 1;
        next_dr[drLen(ir) - 1] = tdiS2;
      end
      if (tap == jisp_pkg::TAP_UPD_DR && seq == jisp_pkg::SEQ_ISP) begin
        if (ir == jisp_pkg::INS_PROGRAM) begin
          next_addr = dr[ADDR_W-1:0];
          next_wdata = dr[ADDR_W +: DATA_W];
          next_seq = jisp_pkg::SEQ_PROG;
          next_timer = 32'(jisp_pkg::PROG_CYCLES - 1);
        end else if (ir == jisp_pkg::INS_READ) begin
          next_addr = dr[ADDR_W-1:0];
          next_readPending = 1'b1;
        end
      end
    end
    // ==========================================================
    // stage sequencer; a read waits for buffer room (back-pressure)
    unique case (seq)
      jisp_pkg::SEQ_USER: begin
      end
      jisp_pkg::SEQ_ISP: begin
        if (readPending && fifoInReady && !tckRise) begin
          next_seq = jisp_pkg::SEQ_READ;
          next_timer = 32'(jisp_pkg::READ_CYCLES - 1);
          next_readPending = 1'b0;
        end
      end
      default: begin
        if (timer != 32'h0) begin
          next_timer = timer - 32'h1;
        end else begin
          next_seq = jisp_pkg::SEQ_ISP;
          unique case (seq)
            jisp_pkg::SEQ_EXIT: next_seq = jisp_pkg::SEQ_USER;
            jisp_pkg::SEQ_ERASE: begin
              memErase = 1'b1;
              next_done = 1'b0;
            end
            jisp_pkg::SEQ_PROG: begin
              memWrite = 1'b1;
              // top address holds the completion flag, programmed last
              if (addr == '1) begin
                next_done = wdata[0];
              end
            end
            jisp_pkg::SEQ_READ: fifoPush = 1'b1;
            default: begin
            end
          endcase
        end
      end
    endcase
    // output data changes on the falling test clock edge
    if (tckFall) begin
      next_tdoEnable = (tap == jisp_pkg::TAP_SHIFT_IR) || (tap == jisp_pkg::TAP_SHIFT_DR);
      next_tdo = (tap == jisp_pkg::TAP_SHIFT_IR) ? irShift[0] : dr[0];
    end
    // pins leave user mode at once on entry, return only after exit completes;
    // both controls come from flops so each changes at most once
    next_pullUpEnable = (next_seq != jisp_pkg::SEQ_USER);
    next_userOutEnable = (next_seq == jisp_pkg::SEQ_USER) && next_done;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tap <= jisp_pkg::TAP_RESET;
      seq <= jisp_pkg::SEQ_USER;
      ir <= jisp_pkg::IR_RESET;
      irShift <= jisp_pkg::IR_CAPTURE;
      dr <= 32'h0;
      timer <= 32'h0;
      addr <= '0;
      wdata <= '0;
      readPending <= 1'b0;
      programmingCompleteFlag <= jisp_pkg::RESET_DONE_FLAG;
      tdo <= 1'b0;
      tdoEnable <= 1'b0;
      userOutEnable <= 1'b0;
      pullUpEnable <= 1'b0;
    end else begin
      tap <= next_tap;
      seq <= next_seq;
      ir <= next_ir;
      irShift <= next_irShift;
      dr <= next_dr;
      timer <= next_timer;
      addr <= next_addr;
      wdata <= next_wdata;
      readPending <= next_readPending;
      programmingCompleteFlag <= next_done;
      tdo <= next_tdo;
      tdoEnable <= next_tdoEnable;
      userOutEnable <= next_userOutEnable;
      pullUpEnable <= next_pullUpEnable;
    end
  end

  // cell array: erase sets every bit, a program pulse writes one word;
  // no reset, the contents stand for nonvolatile cells
  always_ff @(posedge clk) begin
    if (memErase) begin
      for (int i = 0; i < 2**ADDR_W; i++) begin
        cells[i] <= '1;
      end
    end else if (memWrite) begin
      cells[addr] <= wdata;
    end
  end

  // ==========================================================
  // verify read-back buffer between read pulses and the scan chain
  jisp_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(jisp_pkg::FIFO_DEPTH)
  ) readBuf (
    .clk(clk),
    .reset(reset),
    .inValid(fifoPush),
    .inReady(fifoInReady),
    .inData(cells[addr]),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOutData)
  );
endmodule // jisp_sequencer

// file: dv/jisp_sequencer_properties.sv
`timescale 1ns/1ps
module jisp_sequencer_properties #(
  parameter int ENTER_CYCLES = 50,
  parameter int EXIT_CYCLES = 50
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdoEnable,
  input wire logic userOutEnable,
  input wire logic pullUpEnable,
  input wire logic programmingCompleteFlag
);
  // ==========
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  int hiCount; // cycles spent with pins pulled up
  int next_hiCount;
  // counter restarts whenever the pull-ups are released
  always_comb begin
    next_hiCount = pullUpEnable ? hiCount + 1 : 0;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hiCount <= 0;
    end else begin
      hiCount <= next_hiCount;
    end
  end
  // ==========
  // stage edges as seen at the pins
  sequence enterSeen;
    $rose(pullUpEnable);
  endsequence
  sequence exitSeen;
    $fell(pullUpEnable);
  endsequence
  a_pins_exclusive: assert property (!(userOutEnable && pullUpEnable))
    else $error("pins driven while pulled up");
  a_user_needs_flag: assert property (userOutEnable |-> programmingCompleteFlag)
    else $error("pins driven without completion flag");
  a_enter_quiets: assert property (enterSeen |-> !userOutEnable)
    else $error("pins still driven on entry");
  a_drop_on_enter: assert property ($fell(userOutEnable) |-> enterSeen)
    else $error("pin drive dropped outside entry");
  a_exit_restores: assert property (exitSeen |-> userOutEnable == programmingCompleteFlag)
    else $error("pin drive on exit does not follow flag");
  a_user_after_exit: assert property ($rose(userOutEnable) |-> exitSeen)
    else $error("pin drive rose outside exit");
  a_stage_length: assert property (exitSeen |-> hiCount >= ENTER_CYCLES + EXIT_CYCLES)
    else $error("programming mode shorter than entry plus exit");
  a_flag_in_isp: assert property ($changed(programmingCompleteFlag) |-> pullUpEnable)
    else $error("completion flag changed in user mode");
  a_tdo_after_fall: assert property (($changed(tdo) || $changed(tdoEnable)) |-> !tck)
    else $error("scan output moved while scan clock high");
endmodule // jisp_sequencer_properties

bind jisp_sequencer jisp_sequencer_properties #(
  .ENTER_CYCLES(ENTER_CYCLES),
  .EXIT_CYCLES(EXIT_CYCLES)
) props (.clk(clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
  .tdoEnable(tdoEnable), .userOutEnable(userOutEnable), .pullUpEnable(pullUpEnable),
  .programmingCompleteFlag(programmingCompleteFlag));

// file: dv/jisp_host_model.sv
`timescale 1ns/1ps
module jisp_host_model (
  input wire logic clk,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi
);
  // ==========
  // scan clock stands low outside frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one 80 ns scan clock; tdo taken at the rise, pins move at the fall
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #40 tck = 1'b1;
    q = tdo;
    #40 tck = 1'b0;
  endtask
  // one frame through shift state, lsb first, back to idle
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
                      output logic [31:0] dout);
    logic q;
    dout = 32'h0;
    @(posedge clk);
    #1;
    step(1'b1, 1'b0, q);
    if (ir) begin
      step(1'b1, 1'b0, q);
    end
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    tdi = ~tdi; // released line must not keep its last bit
  endtask
  // five high clocks reach test reset, one low lands in idle
  task automatic toIdle();
    logic q;
    @(posedge clk);
    #1;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule // jisp_host_model

// file: dv/test_jtag_isp_programming_sequencer.sv
`timescale 1ns/1ps
module test_jtag_isp_programming_sequencer;
  // ==========
  // short stage counts keep the run brief
  localparam int ENTER_N = 60;
  localparam int EXIT_N = 60;
  localparam int ERASE_N = 120;
  localparam logic [31:0] ID_VAL = 32'h1234_5678; // arbitrary value, lsb clear on purpose
  localparam logic [31:0] USER_VAL = 32'h0000_c0de; // arbitrary value
  logic clk, reset, tck, tms, tdi, tdo, tdoEnable, tdoLine;
  logic userOutEnable, pullUpEnable, programmingCompleteFlag;
  logic [31:0] got; // last frame shifted out
  int errCount, nChecks;
  assign tdoLine = tdoEnable ? tdo : 1'b1; // pulled up when not driven
  jisp_sequencer #(.ID_CODE(ID_VAL), .USER_CODE(USER_VAL), .ENTER_CYCLES(ENTER_N),
    .EXIT_CYCLES(EXIT_N), .ERASE_CYCLES(ERASE_N)) DUT (.clk(clk), .reset(reset),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEnable(tdoEnable),
    .userOutEnable(userOutEnable), .pullUpEnable(pullUpEnable),
    .programmingCompleteFlag(programmingCompleteFlag));
  jisp_host_model host (.clk(clk), .tdo(tdoLine), .tck(tck), .tms(tms), .tdi(tdi));
  always #2.5 clk = ~clk;
  // ==========
  // compare and report helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic finalReport();
    $display("checks %0d, mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic ir(input logic [9:0] code);
    host.scan(1'b1, {22'h0, code}, 10, got);
  endtask
  task automatic dr(input logic [31:0] d, input int n);
    host.scan(1'b0, d, n, got);
  endtask
  // bounded wait: a stuck stage ends the run
  task automatic waitPull(input logic v, input int bound);
    for (int k = 0; k < bound && pullUpEnable !== v; k++) cycles(1);
    check("pullUpEnable wait", pullUpEnable, v);
    if (pullUpEnable !== v) begin
      finalReport();
    end
  endtask
  // ==========
  // scenarios
  task automatic scanIds();
    ir(jisp_pkg::INS_IDCODE);
    check("ir capture", got[9:0], jisp_pkg::IR_CAPTURE);
    dr(32'h0, jisp_pkg::ID_LEN);
    check("id code", got, ID_VAL | 32'h1);
    ir(jisp_pkg::INS_USERCODE);
    dr(32'h0, jisp_pkg::ID_LEN);
    check("user code", got, USER_VAL);
    ir(jisp_pkg::INS_BYPASS);
    dr(32'h3, 2);
    check("bypass", got[1:0], 2'h2);
    check("scan out released", tdoEnable, 1'b0);
  endtask
  task automatic enterStage();
    ir(jisp_pkg::INS_ENTER);
    check("pull-up on entry", pullUpEnable, 1'b1);
    check("drive on entry", userOutEnable, 1'b0);
    cycles(ENTER_N + 10);
  endtask
  task automatic eraseStage();
    ir(jisp_pkg::INS_ERASE);
    cycles(ERASE_N + 10);
    check("flag after erase", programmingCompleteFlag, 1'b0);
  endtask
  // top address last: it carries the completion flag
  task automatic programCells();
    ir(jisp_pkg::INS_PROGRAM);
    dr({8'h0, 16'hbeef, 8'h03}, 24);
    cycles(jisp_pkg::PROG_CYCLES + 14);
    check("flag before last cell", programmingCompleteFlag, 1'b0);
    dr({8'h0, 16'h0001, 8'hff}, 24);
    cycles(jisp_pkg::PROG_CYCLES + 14);
    check("flag after last cell", programmingCompleteFlag, 1'b1);
  endtask
  // each result comes out one read frame later
  task automatic verifyCells(input logic first);
    ir(jisp_pkg::INS_READ);
    dr(32'h03, 16);
    if (first) begin
      check("empty read buffer", got[15:0], 16'h0);
    end
    cycles(jisp_pkg::READ_CYCLES + 10);
    dr(32'hff, 16);
    check("read cell 03", got[15:0], 16'hbeef);
    cycles(jisp_pkg::READ_CYCLES + 10);
    dr(32'h05, 16);
    check("read cell ff", got[15:0], 16'h0001);
    cycles(jisp_pkg::READ_CYCLES + 10);
    dr(32'h05, 16);
    check("read erased cell", got[15:0], 16'hffff);
    cycles(jisp_pkg::READ_CYCLES + 10);
  endtask
  task automatic exitStage(input logic expUser);
    ir(jisp_pkg::INS_EXIT);
    cycles(EXIT_N / 2);
    check("pull-up during exit", pullUpEnable, 1'b1);
    waitPull(1'b0, EXIT_N);
    check("drive after exit", userOutEnable, expUser);
  endtask
  // ==========
  // main sequence: full run, verify-only run, interrupted run
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    errCount = 0;
    nChecks = 0;
    cycles(3);
    reset = 1'b0;
    cycles(2);
    check("drive after reset", userOutEnable, 1'b0);
    check("pull-up after reset", pullUpEnable, 1'b0);
    host.toIdle();
    enterStage();
    scanIds();
    eraseStage();
    programCells();
    verifyCells(1'b1);
    exitStage(1'b1);
    enterStage();
    scanIds();
    verifyCells(1'b0);
    exitStage(1'b1);
    enterStage();
    eraseStage();
    exitStage(1'b0);
    finalReport();
  end
  // hang guard
  initial begin
    #400000;
    errCount++;
    $display("unexpected run length: expected end, seen hang");
    finalReport();
  end
endmodule // test_jtag_isp_programming_sequencer
